// ===== strap_cfg_pkg.sv
// constants, types and decode functions for the strap address and sync configuration block
package strap_cfg_pkg;

   // ---------------------------------------------------------------
   // clocking
   // ---------------------------------------------------------------
   localparam int SYS_HZ          = 10_000_000;
   localparam int HZ_PER_KHZ      = 1000;
   localparam int DEG_FULL        = 360;
   localparam logic [3:0] SETTLE_CYC = 4'h4;

   // ---------------------------------------------------------------
   // address layout
   // ---------------------------------------------------------------
   localparam logic [7:0] DEV_ADDR_RST  = 8'h4F;
   localparam logic [7:0] RAIL_ADDR_RST = 8'h80;
   localparam logic [7:0] ADDR_DISABLE  = 8'h80;
   localparam logic [6:0] GLOBAL_A      = 7'h5A;
   localparam logic [6:0] GLOBAL_B      = 7'h5B;
   localparam int         ADDR_DIS_BIT  = 7;
   localparam logic [4:0] STRAP_OPEN    = 5'h00;
   localparam logic [4:0] ASTRAP_TOP    = 5'h10;

   // ---------------------------------------------------------------
   // command port
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_DEV_ADDR  = 8'h01;
   localparam logic [7:0] CMD_RAIL_ADDR = 8'h02;
   localparam logic [7:0] CMD_FREQ      = 8'h03;
   localparam logic [7:0] CMD_PHASE     = 8'h04;
   localparam logic [7:0] CMD_STATUS    = 8'h05;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } cmd_req_t;

   // ---------------------------------------------------------------
   // match kinds
   // ---------------------------------------------------------------
   localparam logic [1:0] HIT_NONE   = 2'h0;
   localparam logic [1:0] HIT_DEV    = 2'h1;
   localparam logic [1:0] HIT_RAIL   = 2'h2;
   localparam logic [1:0] HIT_GLOBAL = 2'h3;

   // ---------------------------------------------------------------
   // frequency and phase
   // ---------------------------------------------------------------
   localparam logic [3:0] FREQ_250  = 4'h0;
   localparam logic [3:0] FREQ_350  = 4'h1;
   localparam logic [3:0] FREQ_425  = 4'h2;
   localparam logic [3:0] FREQ_500  = 4'h3;
   localparam logic [3:0] FREQ_575  = 4'h4;
   localparam logic [3:0] FREQ_650  = 4'h5;
   localparam logic [3:0] FREQ_750  = 4'h6;
   localparam logic [3:0] FREQ_1000 = 4'h7;
   localparam logic [3:0] FREQ_EXT  = 4'h8;
   localparam logic [8:0] PH_0      = 9'h000;
   localparam logic [8:0] PH_120    = 9'h078;
   localparam logic [8:0] PH_180    = 9'h0B4;
   localparam logic [8:0] PH_MAX    = 9'h167;

   typedef struct packed {
      logic [3:0] freq;
      logic [8:0] phase;
   } freq_phase_t;

   typedef enum logic [2:0] {
      ST_SETTLE = 3'h1,
      ST_LOAD   = 3'h2,
      ST_RUN    = 3'h4
   } cfg_state_t;

   function automatic logic [7:0] per_of_khz(input int khz);
      per_of_khz = 8'(SYS_HZ / (khz * HZ_PER_KHZ));
   endfunction : per_of_khz

   function automatic logic [7:0] freq_period(input logic [3:0] f);
      case (f)
         FREQ_250:  freq_period = per_of_khz(250);
         FREQ_350:  freq_period = per_of_khz(350);
         FREQ_425:  freq_period = per_of_khz(425);
         FREQ_500:  freq_period = per_of_khz(500);
         FREQ_575:  freq_period = per_of_khz(575);
         FREQ_650:  freq_period = per_of_khz(650);
         FREQ_750:  freq_period = per_of_khz(750);
         default:   freq_period = per_of_khz(1000);
      endcase
   endfunction : freq_period

   // linked strap code: 1..14 table entries, 15..31 external clock
   function automatic freq_phase_t freq_strap(input logic [4:0] c);
      case (c)
         5'h01:   freq_strap = '{FREQ_250, PH_0};
         5'h02:   freq_strap = '{FREQ_250, PH_120};
         5'h03:   freq_strap = '{FREQ_250, PH_180};
         5'h04:   freq_strap = '{FREQ_425, PH_0};
         5'h05:   freq_strap = '{FREQ_425, PH_120};
         5'h06:   freq_strap = '{FREQ_425, PH_180};
         5'h07:   freq_strap = '{FREQ_500, PH_0};
         5'h08:   freq_strap = '{FREQ_500, PH_180};
         5'h09:   freq_strap = '{FREQ_575, PH_0};
         5'h0A:   freq_strap = '{FREQ_575, PH_120};
         5'h0B:   freq_strap = '{FREQ_575, PH_180};
         5'h0C:   freq_strap = '{FREQ_650, PH_0};
         5'h0D:   freq_strap = '{FREQ_650, PH_120};
         5'h0E:   freq_strap = '{FREQ_650, PH_180};
         default: freq_strap = '{FREQ_EXT, PH_0};
      endcase
   endfunction : freq_strap

endpackage : strap_cfg_pkg

// ===== two_flop_sync.sv
// two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module two_flop_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_ff <= '0;
         q_out   <= '0;
      end else begin
         meta_ff <= d_in;
         q_out   <= meta_ff;
      end
   end
endmodule : two_flop_sync

// ===== sync_fall_catch.sv
// sync line domain: flips a toggle on every falling edge of the shared sync line
`timescale 1ns/1ps
module sync_fall_catch (
   input  wire logic sync_clk_in,
   input  wire logic rst_in,
   output logic      fall_tog_out
);
   always_ff @(negedge sync_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fall_tog_out <= 1'b0;
      end else begin
         fall_tog_out <= ~fall_tog_out;
      end
   end
endmodule : sync_fall_catch

// ===== strap_address_and_sync_config.sv
// strap address builder, address matcher and sync frequency/phase configuration
//
// What this block does
// - bus address = three stored upper bits plus four strap-decoded low bits, or the whole stored address when the address strap is open
// - stored 0x4F with strap gives addresses 0x40 through 0x4F
// - addresses 0x5A and 0x5B always match as global addresses
// - an address setting holding 0x80 matches nothing
// - a disabled setting never blocks the global addresses
// - a disabled setting never blocks the other address setting
// - rail address uses the same disable encoding, but all seven address bits come from the stored setting, with no strap bits
// - 8-bit address form is the 7-bit address shifted left, R/W bit low
// - strap sets frequency and phase together; commands set them independently
// - one device drives sync; all others take external clock
// - every phase offset counts from the sync falling edge
// - strap code six gives 425kHz, 180 degrees, sync driven
// - external-clock strap code gives 0 degrees from sync fall
// - 350, 750 and 1000kHz only reachable through stored settings or frequency commands
`timescale 1ns/1ps
module strap_address_and_sync_config
   import strap_cfg_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   input  wire logic [4:0]  address_strap_pin_in,
   input  wire logic [4:0]  frequency_strap_pin_in,
   input  wire logic [7:0]  stored_dev_addr_in,
   input  wire logic [7:0]  stored_rail_addr_in,
   input  wire logic [3:0]  stored_freq_in,
   input  wire logic [8:0]  stored_phase_in,
   input  wire cmd_req_t    cmd_in,
   input  wire logic        addr_valid_in,
   input  wire logic [7:0]  addr_byte_in,
   input  wire logic        sync_clk_in,
   output logic             cmd_ack_out,
   output logic [15:0]      cmd_rdata_out,
   output logic             addr_match_out,
   output logic [1:0]       addr_kind_out,
   output logic [6:0]       dev_addr7_out,
   output logic             sync_drv_out,
   output logic             sync_oe_out,
   output logic             sw_start_out,
   output logic             cfg_ready_out
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      cfg_state_t  st;
      logic [3:0]  settle;
      logic        astrap_open;
      logic [3:0]  astrap_lsb;
      logic [7:0]  dev_addr;
      logic [7:0]  rail_addr;
      logic [7:0]  eff_addr;
      logic [3:0]  freq;
      logic [8:0]  phase;
      logic        strap_mode;
      logic [7:0]  div_cnt;
      logic        sync_drv;
      logic        sync_oe;
      logic        tog_seen;
      logic [7:0]  meas_cnt;
      logic [7:0]  meas_per;
      logic [7:0]  dly_cnt;
      logic        dly_run;
      logic        sw_start;
      logic        match;
      logic [1:0]  kind;
      logic [15:0] rdata;
      logic        ack;
      logic        ready;
   } ctl_t;

   ctl_t ctl_ff;
   ctl_t nxt_ctl;

   // ---------------------------------------------------------------
   // crossings
   // ---------------------------------------------------------------
   logic [4:0] astrap_s;
   logic [4:0] fstrap_s;
   logic       fall_tog;
   logic       fall_tog_s;

   two_flop_sync #(.W(5)) u_astrap_sync (
      .clk_in (clk_sys_in),
      .rst_in (sys_rst_in),
      .d_in   (address_strap_pin_in),
      .q_out  (astrap_s)
   );

   two_flop_sync #(.W(5)) u_fstrap_sync (
      .clk_in (clk_sys_in),
      .rst_in (sys_rst_in),
      .d_in   (frequency_strap_pin_in),
      .q_out  (fstrap_s)
   );

   sync_fall_catch u_fall (
      .sync_clk_in  (sync_clk_in),
      .rst_in       (sys_rst_in),
      .fall_tog_out (fall_tog)
   );

   two_flop_sync #(.W(1)) u_fall_sync (
      .clk_in (clk_sys_in),
      .rst_in (sys_rst_in),
      .d_in   (fall_tog),
      .q_out  (fall_tog_s)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic addr_hit(input logic [7:0] cfg, input logic [6:0] a7);
      addr_hit = !cfg[ADDR_DIS_BIT] && (cfg[6:0] == a7);
   endfunction : addr_hit

   function automatic logic [7:0] phase_dly(input logic [7:0] per, input logic [8:0] ph);
      logic [16:0] prod;
      prod = 17'(per) * 17'(ph);
      phase_dly = 8'(prod / 17'(DEG_FULL));
   endfunction : phase_dly

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic        fall_ev;
   logic [6:0]  rx_a7;
   logic [7:0]  own_per;
   logic [7:0]  use_per;
   freq_phase_t fp;

   always_comb begin
      nxt_ctl  = ctl_ff;
      fall_ev  = fall_tog_s ^ ctl_ff.tog_seen;
      rx_a7    = addr_byte_in[7:1];
      own_per  = freq_period(ctl_ff.freq);
      use_per  = ctl_ff.sync_oe ? own_per : ctl_ff.meas_per;
      fp       = freq_strap(fstrap_s);
      nxt_ctl.tog_seen = fall_tog_s;
      nxt_ctl.ack      = 1'b0;
      nxt_ctl.match    = 1'b0;
      nxt_ctl.sw_start = 1'b0;

      case (ctl_ff.st)
         ST_SETTLE: begin
            nxt_ctl.settle = ctl_ff.settle + 4'h1;
            if (ctl_ff.settle == SETTLE_CYC) begin
               nxt_ctl.st = ST_LOAD;
            end
         end
         ST_LOAD: begin
            nxt_ctl.dev_addr    = stored_dev_addr_in;
            nxt_ctl.rail_addr   = stored_rail_addr_in;
            nxt_ctl.astrap_open = (astrap_s == STRAP_OPEN);
            nxt_ctl.astrap_lsb  = 4'(ASTRAP_TOP - astrap_s);
            if (fstrap_s == STRAP_OPEN) begin
               nxt_ctl.freq       = stored_freq_in;
               nxt_ctl.phase      = stored_phase_in;
               nxt_ctl.strap_mode = 1'b0;
            end else begin
               nxt_ctl.freq       = fp.freq;
               nxt_ctl.phase      = fp.phase;
               nxt_ctl.strap_mode = 1'b1;
            end
            nxt_ctl.st = ST_RUN;
         end
         ST_RUN: begin
            if (cmd_in.valid) begin
               nxt_ctl.ack   = 1'b1;
               nxt_ctl.rdata = 16'h0000;
               case (cmd_in.code)
                  CMD_DEV_ADDR: begin
                     nxt_ctl.rdata = {8'h00, ctl_ff.dev_addr};
                     if (cmd_in.write) begin
                        nxt_ctl.dev_addr = cmd_in.wdata[7:0];
                     end
                  end
                  CMD_RAIL_ADDR: begin
                     nxt_ctl.rdata = {8'h00, ctl_ff.rail_addr};
                     if (cmd_in.write) begin
                        nxt_ctl.rail_addr = cmd_in.wdata[7:0];
                     end
                  end
                  CMD_FREQ: begin
                     nxt_ctl.rdata = {12'h000, ctl_ff.freq};
                     if (cmd_in.write && cmd_in.wdata[3:0] <= FREQ_EXT) begin
                        nxt_ctl.freq       = cmd_in.wdata[3:0];
                        nxt_ctl.strap_mode = 1'b0;
                     end
                  end
                  CMD_PHASE: begin
                     nxt_ctl.rdata = {7'h00, ctl_ff.phase};
                     if (cmd_in.write && cmd_in.wdata[8:0] <= PH_MAX) begin
                        nxt_ctl.phase      = cmd_in.wdata[8:0];
                        nxt_ctl.strap_mode = 1'b0;
                     end
                  end
                  CMD_STATUS: begin
                     nxt_ctl.rdata = {5'h00, ctl_ff.strap_mode, ctl_ff.sync_oe, ctl_ff.astrap_open,
                                      ctl_ff.eff_addr};
                  end
                  default: begin
                     nxt_ctl.rdata = 16'h0000;
                  end
               endcase
            end
         end
         default: begin
            nxt_ctl.st = ST_SETTLE;
         end
      endcase

      // effective device address, built from this cycle's settings so it never trails a load or write
      nxt_ctl.ready = (nxt_ctl.st == ST_RUN);
      if (nxt_ctl.astrap_open) begin
         nxt_ctl.eff_addr = nxt_ctl.dev_addr;
      end else begin
         nxt_ctl.eff_addr = {nxt_ctl.dev_addr[7:4], nxt_ctl.astrap_lsb};
      end

      // address matching, global first
      if (addr_valid_in && ctl_ff.st == ST_RUN) begin
         if (rx_a7 == GLOBAL_A || rx_a7 == GLOBAL_B) begin
            nxt_ctl.match = 1'b1;
            nxt_ctl.kind  = HIT_GLOBAL;
         end else if (addr_hit(ctl_ff.eff_addr, rx_a7)) begin
            nxt_ctl.match = 1'b1;
            nxt_ctl.kind  = HIT_DEV;
         end else if (addr_hit(ctl_ff.rail_addr, rx_a7)) begin
            nxt_ctl.match = 1'b1;
            nxt_ctl.kind  = HIT_RAIL;
         end else begin
            nxt_ctl.kind  = HIT_NONE;
         end
      end

      // sync driver: only when not set to external clock
      nxt_ctl.sync_oe = (ctl_ff.st == ST_RUN) && (ctl_ff.freq != FREQ_EXT);
      if (ctl_ff.sync_oe) begin
         if (ctl_ff.div_cnt >= own_per - 8'h01) begin
            nxt_ctl.div_cnt = 8'h00;
         end else begin
            nxt_ctl.div_cnt = ctl_ff.div_cnt + 8'h01;
         end
         nxt_ctl.sync_drv = (nxt_ctl.div_cnt < (own_per >> 1));
      end else begin
         nxt_ctl.div_cnt  = 8'h00;
         nxt_ctl.sync_drv = 1'b0;
      end

      // period of the incoming sync line
      if (fall_ev) begin
         nxt_ctl.meas_cnt = 8'h00;
         nxt_ctl.meas_per = ctl_ff.meas_cnt + 8'h01;
      end else if (ctl_ff.meas_cnt != 8'hFF) begin
         nxt_ctl.meas_cnt = ctl_ff.meas_cnt + 8'h01;
      end

      // phase delay from the sync falling edge
      if (fall_ev && ctl_ff.st == ST_RUN) begin
         nxt_ctl.dly_cnt = phase_dly(use_per, ctl_ff.phase);
         nxt_ctl.dly_run = 1'b1;
      end else if (ctl_ff.dly_run) begin
         if (ctl_ff.dly_cnt == 8'h00) begin
            nxt_ctl.sw_start = 1'b1;
            nxt_ctl.dly_run  = 1'b0;
         end else begin
            nxt_ctl.dly_cnt = ctl_ff.dly_cnt - 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctl_ff            <= '0;
         ctl_ff.st         <= ST_SETTLE;
         ctl_ff.dev_addr   <= DEV_ADDR_RST;
         ctl_ff.rail_addr  <= RAIL_ADDR_RST;
         ctl_ff.eff_addr   <= DEV_ADDR_RST;
         ctl_ff.astrap_open <= 1'b1;
         ctl_ff.freq       <= FREQ_EXT;
         ctl_ff.phase      <= PH_0;
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cmd_ack_out    = ctl_ff.ack;
   assign cmd_rdata_out  = ctl_ff.rdata;
   assign addr_match_out = ctl_ff.match;
   assign addr_kind_out  = ctl_ff.kind;
   assign dev_addr7_out  = ctl_ff.eff_addr[6:0];
   assign sync_drv_out   = ctl_ff.sync_drv;
   assign sync_oe_out    = ctl_ff.sync_oe;
   assign sw_start_out   = ctl_ff.sw_start;
   assign cfg_ready_out  = ctl_ff.ready;

endmodule : strap_address_and_sync_config

// ===== strap_cfg_asserts.sv
// checker for the strap address and sync configuration block
`timescale 1ns/1ps
module strap_cfg_asserts
   import strap_cfg_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   input  wire logic [4:0] address_strap_pin_in,
   input  wire logic [4:0] frequency_strap_pin_in,
   input  wire logic [7:0] stored_dev_addr_in,
   input  wire logic [3:0] stored_freq_in,
   input  wire cmd_req_t   cmd_in,
   input  wire logic       addr_valid_in,
   input  wire logic [7:0] addr_byte_in,
   input  wire logic       cmd_ack_out,
   input  wire logic       addr_match_out,
   input  wire logic [1:0] addr_kind_out,
   input  wire logic [6:0] dev_addr7_out,
   input  wire logic       sync_drv_out,
   input  wire logic       sync_oe_out,
   input  wire logic       sw_start_out,
   input  wire logic       cfg_ready_out
);
   localparam int PER_425 = 23;
   logic       seen_ff;
   logic       drv_q_ff;
   logic [7:0] gap_ff;
   logic [1:0] rises_ff;
   logic       rise;

   assign rise = sync_drv_out & ~drv_q_ff;

   // ---------------------------------------------------------------
   // helper: command seen, cycles between rises of the driven sync
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         seen_ff  <= 1'b0;
         drv_q_ff <= 1'b0;
         gap_ff   <= 8'h00;
         rises_ff <= 2'h0;
      end else begin
         seen_ff  <= seen_ff | (cmd_in.valid & cfg_ready_out);
         drv_q_ff <= sync_drv_out;
         gap_ff   <= rise ? 8'h01 : ((gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01);
         rises_ff <= (rise && sync_oe_out && rises_ff != 2'h3) ? rises_ff + 2'h1 : rises_ff;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   a_global_hit: assert property (addr_valid_in && cfg_ready_out &&
      (addr_byte_in[7:1] == GLOBAL_A || addr_byte_in[7:1] == GLOBAL_B)
      |=> addr_match_out && addr_kind_out == HIT_GLOBAL) else $error("global address not matched");
   a_dev_hit_cause: assert property (addr_match_out && addr_kind_out == HIT_DEV
      |-> ({1'b0, $past(dev_addr7_out)} == ($past(addr_byte_in) >> 1))) else $error("device hit on wrong byte");
   a_match_pulse: assert property (addr_match_out
      |-> $past(addr_valid_in) && addr_kind_out != HIT_NONE) else $error("match without request");
   a_strap_low: assert property (cfg_ready_out && !seen_ff |-> dev_addr7_out ==
      ((address_strap_pin_in == STRAP_OPEN) ? stored_dev_addr_in[6:0]
      : {stored_dev_addr_in[6:4], 4'(ASTRAP_TOP - address_strap_pin_in)})) else $error("bad effective address");
   a_sync_mode: assert property (cfg_ready_out && $past(cfg_ready_out) && !seen_ff
      |-> sync_oe_out == ((frequency_strap_pin_in == STRAP_OPEN) ? (stored_freq_in != FREQ_EXT)
      : (frequency_strap_pin_in < 5'h0F))) else $error("sync drive mode wrong");
   a_drv_period: assert property (rise && rises_ff == 2'h3 && sync_oe_out && !seen_ff
      && frequency_strap_pin_in == 5'h06 |-> gap_ff == 8'(PER_425)) else $error("driven sync period wrong");
   a_phase_delay: assert property ($fell(sync_drv_out) && sync_oe_out && cfg_ready_out && !seen_ff
      && frequency_strap_pin_in == 5'h06 |-> ##[12:17] sw_start_out) else $error("phase start missing");
   a_ack_follow: assert property (cmd_in.valid && cfg_ready_out |=> cmd_ack_out)
      else $error("command not acknowledged");
   a_run_only: assert property (sw_start_out || addr_match_out || cmd_ack_out
      |-> $past(cfg_ready_out)) else $error("activity before run");
endmodule : strap_cfg_asserts

bind strap_address_and_sync_config strap_cfg_asserts u_chk (
   .clk_sys_in             (clk_sys_in),
   .sys_rst_in             (sys_rst_in),
   .address_strap_pin_in   (address_strap_pin_in),
   .frequency_strap_pin_in (frequency_strap_pin_in),
   .stored_dev_addr_in     (stored_dev_addr_in),
   .stored_freq_in         (stored_freq_in),
   .cmd_in                 (cmd_in),
   .addr_valid_in          (addr_valid_in),
   .addr_byte_in           (addr_byte_in),
   .cmd_ack_out            (cmd_ack_out),
   .addr_match_out         (addr_match_out),
   .addr_kind_out          (addr_kind_out),
   .dev_addr7_out          (dev_addr7_out),
   .sync_drv_out           (sync_drv_out),
   .sync_oe_out            (sync_oe_out),
   .sw_start_out           (sw_start_out),
   .cfg_ready_out          (cfg_ready_out)
);

// ===== sync_peer.sv
// far-side controller that drives the shared sync line for external-clock devices
`timescale 1ns/1ps
module sync_peer (
   input  wire logic enable_in,
   output logic      sync_out
);
   initial begin
      sync_out = 1'b1; // pulled-up line idles high
      #37;
      forever begin
         if (enable_in) begin
            #80;
            sync_out = 1'b0;
            #80;
            sync_out = 1'b1;
         end else begin
            #10;
         end
      end
   end
endmodule : sync_peer

// ===== strap_address_and_sync_config_tb_top.sv
// self-checking bench for the strap address and sync configuration block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin errors++; $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end
module strap_address_and_sync_config_tb_top
   import strap_cfg_pkg::*;
;
   logic        clk_sys_in, sys_rst_in, av, peer_en, peer_sync, sync_w;
   logic [4:0]  astrap, fstrap;
   logic [7:0]  dev_st, rail_st, ab;
   logic [3:0]  freq_st;
   logic [8:0]  ph_st;
   cmd_req_t    cmd;
   logic        ack, match, drv, oe, start, ready;
   logic [15:0] rdata, r;
   logic [1:0]  kind;
   logic [6:0]  a7;
   int          errors, checks_done, cyc, n;

   assign sync_w = oe ? drv : peer_sync;

   strap_address_and_sync_config uut (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .address_strap_pin_in(astrap),
      .frequency_strap_pin_in(fstrap), .stored_dev_addr_in(dev_st), .stored_rail_addr_in(rail_st),
      .stored_freq_in(freq_st), .stored_phase_in(ph_st), .cmd_in(cmd), .addr_valid_in(av),
      .addr_byte_in(ab), .sync_clk_in(sync_w), .cmd_ack_out(ack), .cmd_rdata_out(rdata),
      .addr_match_out(match), .addr_kind_out(kind), .dev_addr7_out(a7), .sync_drv_out(drv),
      .sync_oe_out(oe), .sw_start_out(start), .cfg_ready_out(ready));

   sync_peer peer (.enable_in(peer_en), .sync_out(peer_sync));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic close_out;
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task automatic do_reset(input logic [4:0] a, input logic [4:0] f);
      @(posedge clk_sys_in);
      astrap     <= a;
      fstrap     <= f;
      sys_rst_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      n = 0;
      #1;
      while (ready !== 1'b1 && n < 20) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      `CHK("ready", 1'b1, ready)
   endtask : do_reset

   task automatic do_cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_sys_in);
      cmd <= '{1'b1, w, c, d};
      @(posedge clk_sys_in);
      cmd.valid <= 1'b0;
      #1;
      `CHK("ack", 1'b1, ack)
      r = rdata;
      @(posedge clk_sys_in);
   endtask : do_cmd

   task automatic do_addr(input logic [7:0] b, input logic [1:0] k);
      @(posedge clk_sys_in);
      av <= 1'b1;
      ab <= b;
      @(posedge clk_sys_in);
      av <= 1'b0;
      #1;
      `CHK("match", (k != HIT_NONE), match)
      `CHK("kind", k, kind)
   endtask : do_addr

   // cycles between two rises of the driven sync line
   task automatic gap(output int g);
      logic p;
      int   k;
      p = drv;
      g = 0;
      k = 0;
      while (k < 2 && g < 200) begin
         @(posedge clk_sys_in);
         #1;
         if (drv === 1'b1 && p === 1'b0) k++;
         if (k == 1) g++;
         p = drv;
      end
   endtask : gap

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_default;
      do_reset(5'h00, 5'h00);
      `CHK("addr7", 7'h4F, a7)
      do_addr(8'h9E, HIT_DEV);
      do_addr(8'h9F, HIT_DEV);
      do_addr(8'hB4, HIT_GLOBAL);
      do_addr(8'hB6, HIT_GLOBAL);
      do_addr(8'hC0, HIT_NONE);
      `CHK("oe", 1'b1, oe)
      do_cmd(1'b0, CMD_FREQ, 16'h0000);
      `CHK("nvm_freq", {12'h000, FREQ_350}, r)
      do_cmd(1'b0, CMD_PHASE, 16'h0000);
      `CHK("nvm_phase", {7'h00, PH_120}, r)
   endtask : t_default

   task automatic t_strap;
      for (int c = 1; c <= 16; c++) begin
         do_reset(5'(c), 5'h00);
         `CHK("addr7", {3'h4, 4'(16 - c)}, a7)
         do_addr({3'h4, 4'(16 - c), 1'b0}, HIT_DEV);
         do_addr(8'h9E, (c == 1) ? HIT_DEV : HIT_NONE);
      end
   endtask : t_strap

   task automatic t_disable;
      do_reset(5'h00, 5'h00);
      do_cmd(1'b1, CMD_DEV_ADDR, 16'h0080);
      `CHK("old_dev", 16'h004F, r)
      do_addr(8'h9E, HIT_NONE);
      do_addr(8'hB6, HIT_GLOBAL);
      do_cmd(1'b1, CMD_RAIL_ADDR, 16'h0033);
      do_addr(8'h66, HIT_RAIL);
      do_cmd(1'b1, CMD_RAIL_ADDR, 16'h0080);
      do_addr(8'h66, HIT_NONE);
      do_cmd(1'b1, CMD_DEV_ADDR, 16'h0061);
      do_addr(8'hC2, HIT_DEV);
   endtask : t_disable

   task automatic t_drive;
      int g;
      do_reset(5'h00, 5'h06);
      repeat (2) @(posedge clk_sys_in);
      #1;
      `CHK("oe", 1'b1, oe)
      gap(g);
      `CHK("period", 23, g)
      n = 0;
      repeat (92) begin
         @(posedge clk_sys_in);
         #1;
         if (start === 1'b1) n++;
      end
      `CHK("starts", 4, n)
      do_cmd(1'b1, CMD_PHASE, 16'h0078);
      `CHK("old_phase", 16'h00B4, r)
      do_cmd(1'b0, CMD_FREQ, 16'h0000);
      `CHK("freq", 16'h0002, r)
      do_cmd(1'b1, CMD_FREQ, 16'h0009);
      do_cmd(1'b1, CMD_FREQ, {12'h000, FREQ_750});
      `CHK("kept", 16'h0002, r)
      gap(g);
      gap(g);
      `CHK("period", 13, g)
   endtask : t_drive

   task automatic t_ext;
      peer_en <= 1'b1;
      do_reset(5'h00, 5'h0F);
      `CHK("oe", 1'b0, oe)
      @(negedge sync_w);
      n = 0;
      while (start !== 1'b1 && n < 30) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      `CHK("lag", 1'b1, (n >= 2 && n <= 6))
      do_cmd(1'b0, CMD_STATUS, 16'h0000);
      `CHK("status", 16'h054F, r)
      peer_en <= 1'b0;
   endtask : t_ext

   // ---------------------------------------------------------------
   // clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc > 6000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      astrap = 5'h00;
      fstrap = 5'h00;
      dev_st = DEV_ADDR_RST;
      rail_st = RAIL_ADDR_RST;
      freq_st = FREQ_350;
      ph_st = PH_120;
      cmd = '0;
      av = 1'b0;
      ab = 8'h00;
      peer_en = 1'b0;
      errors = 0;
      checks_done = 0;
      cyc = 0;
      t_default();
      t_strap();
      t_disable();
      t_drive();
      t_ext();
      close_out();
   end
endmodule : strap_address_and_sync_config_tb_top
